// [rtl/pmt_consts.svh]
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// Register indices; the bus address is the index, the byte address is four times it.
`define PMT_IDX_FLAG 8'h0C
`define PMT_IDX_COUNT 8'h11
`define PMT_IDX_CTRL 8'h12
`define PMT_IDX_ENABLE 8'h8C
`define PMT_IDX_PERIOD 8'h92

// Positions in the one-hot register select.
`define PMT_SEL_FLAG 0
`define PMT_SEL_COUNT 1
`define PMT_SEL_CTRL 2
`define PMT_SEL_ENABLE 3
`define PMT_SEL_PERIOD 4

// Field positions.
`define PMT_MATCH_FLAG_BIT 1
`define PMT_MATCH_IE_BIT 1
`define PMT_RUN_BIT 2
`define PMT_PRE_MSB 1
`define PMT_PRE_LSB 0
`define PMT_POST_MSB 6
`define PMT_POST_LSB 3
`define PMT_CTRL_MASK 8'h7F

// Reset values.
`define PMT_ZERO8 8'h00
`define PMT_PERIOD_RST 8'hFF
`define PMT_ZERO32 32'h0000_0000

// Instruction clock is the system clock divided by four.
`define PMT_INSTR_LAST 2'h3

// Last prescaler count for each ratio.
`define PMT_PRE_LAST_1 4'h0
`define PMT_PRE_LAST_4 4'h3
`define PMT_PRE_LAST_16 4'hF
`define PMT_PRE_SEL_1 2'h0
`define PMT_PRE_SEL_4 2'h1

`endif

// [rtl/pmt_pkg.sv]
package pmt_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_type;

endpackage

// [rtl/pmt_prescaler.sv]
`timescale 1ns/100ps
`include "pmt_consts.svh"
module pmt_prescaler (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic enable,
    input wire logic clear,
    input wire logic [1:0] prescale_select,
    // Divided tick
    output logic tick
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [3:0] last;

    function automatic logic [3:0] last_count(input logic [1:0] sel);
        if (sel == `PMT_PRE_SEL_1)
        begin
            return `PMT_PRE_LAST_1;
        end
        else if (sel == `PMT_PRE_SEL_4)
        begin
            return `PMT_PRE_LAST_4;
        end
        return `PMT_PRE_LAST_16;
    endfunction

    always_comb
    begin
        last = last_count(prescale_select);
        tick = enable && !clear && (cnt_reg == last);
        cnt_next = cnt_reg;
        if (clear)
        begin
            cnt_next = 4'h0;
        end
        else if (tick)
        begin
            cnt_next = 4'h0;
        end
        else if (enable)
        begin
            cnt_next = cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 4'h0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_pre_clear: assert property (clear |=> cnt_reg == 4'h0)
        else $error("prescaler not cleared");
    a_pre_ratio: assert property (tick && prescale_select == 2'h1 |-> cnt_reg == 4'h3)
        else $error("prescale 1:4 tick at wrong count");
endmodule // pmt_prescaler

// [rtl/pmt_postscaler.sv]
`timescale 1ns/100ps
`include "pmt_consts.svh"
module pmt_postscaler (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic match,
    input wire logic clear,
    input wire logic [3:0] postscale_select,
    // Every Nth match
    output logic pulse
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    always_comb
    begin
        pulse = match && !clear && (cnt_reg == postscale_select);
        cnt_next = cnt_reg;
        if (clear)
        begin
            cnt_next = 4'h0;
        end
        else if (pulse)
        begin
            cnt_next = 4'h0;
        end
        else if (match)
        begin
            cnt_next = cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 4'h0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_post_ratio: assert property (match && !clear && postscale_select == 4'h0 |-> pulse)
        else $error("postscale 1:1 missed a match");
    a_post_clear: assert property (clear |=> cnt_reg == 4'h0)
        else $error("postscaler not cleared");
endmodule // pmt_postscaler

// [rtl/period_match_timer.sv]
`timescale 1ns/100ps
`include "pmt_consts.svh"
module period_match_timer (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    // Avalon-MM slave
    input wire logic [7:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // Interrupt
    output logic IRQ,
    // Time base for sync serial port and PWM
    output logic MATCH_OUT,
    output logic [7:0] PWM_COUNT
);
    pmt_pkg::bus_state_type state_reg;
    pmt_pkg::bus_state_type state_next;
    logic wait_reg;
    logic wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [4:0] hit;
    logic wr_acc;
    logic count_wr;
    logic ctrl_wr;

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] period_reg;
    logic [7:0] period_next;
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] enable_reg;
    logic [7:0] enable_next;
    logic flag_reg;
    logic flag_next;
    logic irq_reg;
    logic irq_next;
    logic match_reg;
    logic match_now;

    logic [1:0] instr_cnt_reg;
    logic [1:0] instr_cnt_next;
    logic instr_tick;
    logic pre_tick;
    logic post_pulse;
    logic scaler_clear;

    // Decodes a register index into a one-hot select; zero for unmapped indices.
    function automatic logic [4:0] reg_select(input logic [7:0] idx);
        logic [4:0] sel;
        sel = 5'h00;
        case (idx)
            `PMT_IDX_FLAG: sel[`PMT_SEL_FLAG] = 1'b1;
            `PMT_IDX_COUNT: sel[`PMT_SEL_COUNT] = 1'b1;
            `PMT_IDX_CTRL: sel[`PMT_SEL_CTRL] = 1'b1;
            `PMT_IDX_ENABLE: sel[`PMT_SEL_ENABLE] = 1'b1;
            `PMT_IDX_PERIOD: sel[`PMT_SEL_PERIOD] = 1'b1;
            default: sel = 5'h00;
        endcase
        return sel;
    endfunction

    // Bus slave: a request is answered one cycle after it is seen.
    always_comb
    begin
        hit = reg_select(ADDRESS);
        state_next = state_reg;
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        wr_acc = 1'b0;
        case (state_reg)
            pmt_pkg::BUS_IDLE:
            begin
                if (READ || WRITE)
                begin
                    state_next = pmt_pkg::BUS_DONE;
                    wait_next = 1'b0;
                    rdata_next = `PMT_ZERO32;
                    if (READ)
                    begin
                        case (1'b1)
                            hit[`PMT_SEL_FLAG]:
                                rdata_next[`PMT_MATCH_FLAG_BIT] = flag_reg;
                            hit[`PMT_SEL_COUNT]: rdata_next[7:0] = count_reg;
                            hit[`PMT_SEL_CTRL]: rdata_next[7:0] = ctrl_reg;
                            hit[`PMT_SEL_ENABLE]: rdata_next[7:0] = enable_reg;
                            hit[`PMT_SEL_PERIOD]: rdata_next[7:0] = period_reg;
                            default: rdata_next = `PMT_ZERO32;
                        endcase
                    end
                end
            end
            pmt_pkg::BUS_DONE:
            begin
                state_next = pmt_pkg::BUS_IDLE;
                wr_acc = WRITE && BYTEENABLE[0];
            end
            default:
            begin
                state_next = pmt_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state_reg <= pmt_pkg::BUS_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= `PMT_ZERO32;
        end
        else
        begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign count_wr = wr_acc && hit[`PMT_SEL_COUNT];
    assign ctrl_wr = wr_acc && hit[`PMT_SEL_CTRL];
    assign scaler_clear = count_wr || ctrl_wr;

    // Instruction clock enable: one pulse in four system clocks.
    always_comb
    begin
        instr_cnt_next = instr_cnt_reg + 2'h1;
        instr_tick = (instr_cnt_reg == `PMT_INSTR_LAST);
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            instr_cnt_reg <= 2'h0;
        end
        else
        begin
            instr_cnt_reg <= instr_cnt_next;
        end
    end

    pmt_prescaler u_prescaler (
        .clk_sys(CLK_SYS),
        .sys_rst(SYS_RST),
        .enable(instr_tick && ctrl_reg[`PMT_RUN_BIT]),
        .clear(scaler_clear),
        .prescale_select(ctrl_reg[`PMT_PRE_MSB:`PMT_PRE_LSB]),
        .tick(pre_tick)
    );

    pmt_postscaler u_postscaler (
        .clk_sys(CLK_SYS),
        .sys_rst(SYS_RST),
        .match(match_now),
        .clear(scaler_clear),
        .postscale_select(ctrl_reg[`PMT_POST_MSB:`PMT_POST_LSB]),
        .pulse(post_pulse)
    );

    // Counter, period and control registers.
    always_comb
    begin
        count_next = count_reg;
        match_now = 1'b0;
        period_next = period_reg;
        ctrl_next = ctrl_reg;
        if (count_wr)
        begin
            count_next = WRITEDATA[7:0];
        end
        else if (pre_tick)
        begin
            if (count_reg == period_reg)
            begin
                count_next = `PMT_ZERO8;
                match_now = 1'b1;
            end
            else
            begin
                count_next = count_reg + 8'h01;
            end
        end
        if (ctrl_wr)
        begin
            // The count keeps its value; only the scalers are cleared.
            ctrl_next = WRITEDATA[7:0] & `PMT_CTRL_MASK;
        end
        if (wr_acc && hit[`PMT_SEL_PERIOD])
        begin
            period_next = WRITEDATA[7:0];
        end
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            count_reg <= `PMT_ZERO8;
            period_reg <= `PMT_PERIOD_RST;
            ctrl_reg <= `PMT_ZERO8;
            match_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            period_reg <= period_next;
            ctrl_reg <= ctrl_next;
            match_reg <= match_now;
        end
    end

    // Match flag and interrupt; a postscaler event beats a clearing write.
    always_comb
    begin
        flag_next = flag_reg;
        enable_next = enable_reg;
        if (wr_acc && hit[`PMT_SEL_FLAG])
        begin
            flag_next = WRITEDATA[`PMT_MATCH_FLAG_BIT];
        end
        if (post_pulse)
        begin
            flag_next = 1'b1;
        end
        if (wr_acc && hit[`PMT_SEL_ENABLE])
        begin
            enable_next = WRITEDATA[7:0];
        end
        irq_next = flag_next && enable_next[`PMT_MATCH_IE_BIT];
    end

    always_ff @(posedge CLK_SYS or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            flag_reg <= 1'b0;
            enable_reg <= `PMT_ZERO8;
            irq_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            enable_reg <= enable_next;
            irq_reg <= irq_next;
        end
    end

    assign READDATA = rdata_reg;
    assign WAITREQUEST = wait_reg;
    assign IRQ = irq_reg;
    assign MATCH_OUT = match_reg;
    assign PWM_COUNT = count_reg;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    a_count_wrap: assert property (
        pre_tick && !count_wr && count_reg == period_reg |=> count_reg == 8'h00)
        else $error("count did not return to zero after period match");

    a_count_step: assert property (
        pre_tick && !count_wr && count_reg != period_reg
        |=> count_reg == $past(count_reg) + 8'h01)
        else $error("count did not advance by one on a tick");

    a_period_write: assert property (
        wr_acc && hit[`PMT_SEL_PERIOD] |=> period_reg == $past(WRITEDATA[7:0]))
        else $error("period register did not take written value");

    a_count_write: assert property (
        count_wr |=> count_reg == $past(WRITEDATA[7:0]))
        else $error("count did not take written value");

    a_ctrl_keep: assert property (
        ctrl_wr |=> count_reg == $past(count_reg))
        else $error("control write changed the count");

    a_run_stop: assert property (
        !ctrl_reg[`PMT_RUN_BIT] && !count_wr |=> count_reg == $past(count_reg))
        else $error("count moved while stopped");

    a_div1_rate: assert property (
        ctrl_reg[`PMT_RUN_BIT] && ctrl_reg[1:0] == 2'h0 && instr_tick && !scaler_clear
        |-> pre_tick)
        else $error("1:1 prescale missed an instruction tick");

    a_flag_set: assert property (
        post_pulse |=> flag_reg ##0 (match_reg && $past(match_now)))
        else $error("postscaler event did not set the flag");

    a_match_out: assert property (
        match_now |=> MATCH_OUT && PWM_COUNT == 8'h00)
        else $error("match pulse not exported with zero count");

    a_pwm_base: assert property (
        MATCH_OUT |-> $past(count_reg) == $past(period_reg))
        else $error("match exported without period equality");

    a_irq_level: assert property (
        flag_reg && enable_reg[`PMT_MATCH_IE_BIT] |-> IRQ)
        else $error("interrupt low while enabled flag is set");

    a_irq_clear: assert property (
        !flag_reg |-> !IRQ)
        else $error("interrupt high without flag");

    a_bus_answer: assert property (
        state_reg == pmt_pkg::BUS_IDLE && (READ || WRITE) |=> !WAITREQUEST ##1 WAITREQUEST)
        else $error("bus answer not exactly one cycle");
endmodule // period_match_timer

// [test/period_match_timer_tb_top.sv]
`timescale 1ns/100ps
`include "pmt_consts.svh"
module period_match_timer_tb_top;
    logic CLK_SYS;
    logic SYS_RST;
    logic [7:0] ADDRESS;
    logic READ;
    logic WRITE;
    logic [31:0] WRITEDATA;
    logic [3:0] BYTEENABLE;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    logic IRQ;
    logic MATCH_OUT;
    logic [7:0] PWM_COUNT;
    int fails;
    int comparisons;
    int n;
    logic [7:0] max_count;
    logic [31:0] rd;
    logic [3:0] post_list [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
    int ratio_list [4] = '{1, 4, 16, 16};

    period_match_timer u_period_match_timer (
        .CLK_SYS(CLK_SYS),
        .SYS_RST(SYS_RST),
        .ADDRESS(ADDRESS),
        .READ(READ),
        .WRITE(WRITE),
        .WRITEDATA(WRITEDATA),
        .BYTEENABLE(BYTEENABLE),
        .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST),
        .IRQ(IRQ),
        .MATCH_OUT(MATCH_OUT),
        .PWM_COUNT(PWM_COUNT)
    );

    initial
    begin
        CLK_SYS = 1'h0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    task stop_test;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    task check_value(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Waits for the slave to drop waitrequest, sampling at each rising edge.
    // Only the watchdog ends a wait that never gets an answer.
    task wait_answer;
        do
        begin
            @(posedge CLK_SYS);
        end
        while (WAITREQUEST !== 1'h0);
    endtask

    task bus_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge CLK_SYS);
        ADDRESS <= addr;
        WRITEDATA <= {24'h000000, data};
        WRITE <= 1'h1;
        wait_answer();
        WRITE <= 1'h0;
    endtask

    task bus_read(input logic [7:0] addr, output logic [31:0] data);
        @(posedge CLK_SYS);
        ADDRESS <= addr;
        READ <= 1'h1;
        wait_answer();
        data = READDATA;
        READ <= 1'h0;
    endtask

    task read_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
        bus_read(addr, rd);
        check_value(rd, {24'h000000, exp}, what);
    endtask

    // Stops the timer, zeroes count and flag, then starts it with the given control.
    task setup_run(input logic [7:0] ctrl);
        bus_write(`PMT_IDX_CTRL, 8'h00);
        bus_write(`PMT_IDX_COUNT, 8'h00);
        bus_write(`PMT_IDX_FLAG, 8'h00);
        bus_write(`PMT_IDX_CTRL, ctrl);
    endtask

    // Counts clocks between two match pulses and records the highest count seen.
    task measure_gap(output int gap);
        int k;
        k = 0;
        gap = 0;
        max_count = 8'h00;
        do
        begin
            @(posedge CLK_SYS);
            k++;
        end
        while (MATCH_OUT !== 1'h1 && k < 1000);
        do
        begin
            @(posedge CLK_SYS);
            gap++;
            if (PWM_COUNT > max_count)
            begin
                max_count = PWM_COUNT;
            end
        end
        while (MATCH_OUT !== 1'h1 && gap < 1000);
    endtask

    task count_matches(output int cnt);
        int k;
        k = 0;
        cnt = 0;
        do
        begin
            @(posedge CLK_SYS);
            k++;
            if (MATCH_OUT === 1'h1)
            begin
                cnt++;
            end
        end
        while (IRQ !== 1'h1 && k < 1000);
    endtask

    initial
    begin
        #40000;
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        fails = 0;
        comparisons = 0;
        SYS_RST = 1'h1;
        ADDRESS = 8'h00;
        READ = 1'h0;
        WRITE = 1'h0;
        WRITEDATA = 32'h00000000;
        BYTEENABLE = 4'hF;
        repeat (12) @(posedge CLK_SYS);
        SYS_RST <= 1'h0;
        read_check(`PMT_IDX_FLAG, 8'h00, "flag reset");
        read_check(`PMT_IDX_COUNT, 8'h00, "count reset");
        read_check(`PMT_IDX_CTRL, 8'h00, "control reset");
        read_check(`PMT_IDX_ENABLE, 8'h00, "enable reset");
        read_check(`PMT_IDX_PERIOD, 8'hFF, "period reset");
        read_check(8'h13, 8'h00, "unmapped read");
        bus_write(`PMT_IDX_PERIOD, 8'h5A);
        read_check(`PMT_IDX_PERIOD, 8'h5A, "period rw");
        // A write with the low byte lane disabled must leave the register alone.
        BYTEENABLE <= 4'hE;
        bus_write(`PMT_IDX_PERIOD, 8'h33);
        BYTEENABLE <= 4'hF;
        read_check(`PMT_IDX_PERIOD, 8'h5A, "lane disabled write");
        bus_write(`PMT_IDX_ENABLE, 8'hA5);
        read_check(`PMT_IDX_ENABLE, 8'hA5, "enable rw");
        bus_write(`PMT_IDX_CTRL, 8'hF8);
        read_check(`PMT_IDX_CTRL, 8'h78, "control rw");
        bus_write(`PMT_IDX_COUNT, 8'h55);
        repeat (40) @(posedge CLK_SYS);
        read_check(`PMT_IDX_COUNT, 8'h55, "stopped count");
        check_value({24'h000000, PWM_COUNT}, 32'h00000055, "pwm count");
        bus_write(`PMT_IDX_CTRL, 8'h00);
        read_check(`PMT_IDX_COUNT, 8'h55, "count after control write");
        bus_write(8'h13, 8'hFF);
        read_check(8'h13, 8'h00, "unmapped write");
        bus_write(`PMT_IDX_PERIOD, 8'h02);
        for (int i = 0; i < 4; i++)
        begin
            setup_run(8'h04 | 8'(i));
            measure_gap(n);
            check_value(n, 12 * ratio_list[i], "match spacing");
            check_value({24'h000000, max_count}, 32'h00000002, "count top");
        end
        bus_write(`PMT_IDX_PERIOD, 8'h00);
        bus_write(`PMT_IDX_ENABLE, 8'h02);
        for (int i = 0; i < 4; i++)
        begin
            setup_run({1'h0, post_list[i], 3'h4});
            count_matches(n);
            check_value(n, {28'h0000000, post_list[i]} + 32'h1, "postscale");
            check_value({31'h0, IRQ}, 32'h1, "irq raised");
        end
        read_check(`PMT_IDX_FLAG, 8'h02, "flag set");
        bus_write(`PMT_IDX_CTRL, 8'h00);
        bus_write(`PMT_IDX_ENABLE, 8'h00);
        repeat (2) @(posedge CLK_SYS);
        check_value({31'h0, IRQ}, 32'h0, "irq masked");
        read_check(`PMT_IDX_FLAG, 8'h02, "flag sticky");
        bus_write(`PMT_IDX_ENABLE, 8'h02);
        repeat (2) @(posedge CLK_SYS);
        check_value({31'h0, IRQ}, 32'h1, "irq unmasked");
        bus_write(`PMT_IDX_FLAG, 8'h00);
        repeat (2) @(posedge CLK_SYS);
        check_value({31'h0, IRQ}, 32'h0, "irq cleared");
        read_check(`PMT_IDX_FLAG, 8'h00, "flag cleared");
        // A reset with the timer stopped must bring count, period and flag back to their reset values.
        bus_write(`PMT_IDX_PERIOD, 8'h07);
        bus_write(`PMT_IDX_COUNT, 8'h21);
        bus_write(`PMT_IDX_FLAG, 8'h02);
        SYS_RST <= 1'h1;
        repeat (3) @(posedge CLK_SYS);
        check_value({24'h000000, PWM_COUNT}, 32'h00000000, "count in reset");
        SYS_RST <= 1'h0;
        read_check(`PMT_IDX_COUNT, 8'h00, "count after reset");
        read_check(`PMT_IDX_PERIOD, 8'hFF, "period after reset");
        read_check(`PMT_IDX_FLAG, 8'h00, "flag after reset");
        check_value({31'h0, IRQ}, 32'h0, "irq after reset");
        stop_test();
    end
endmodule // period_match_timer_tb_top
